/* File: debug_link_ctrl_status_regs.v */
// control and status registers of the single-wire debug link
// Behaviour
// - any link error loads code; read clears
// - codes 1 parity, 2 stop, 4 start
// - codes 3 timeout, 6 bus, 7 contention
// - gap enable inserts two idle bits in multi-byte loads
// - parity off ignores parity errors
// - timeout after 65536 link cycles unless off
// - reply signature off suppresses signatures
// - guard time 128 down to 2 cycles
// - nack off suppresses nack after reset
// - collision off disables contention detection
// - interface off resets config and keys
// - user row key set; write ends session
// - nvm key set; cleared when programming starts
// - erase key cleared by reset request
// - 0x59 holds system reset, else release
// - system reset leaves link logic alone
// - divider selects 32/16/8/4 MHz, default 4
// - user row done commits, only with key
// - sysclk hold requests clock, default set
`include "debug_link_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module debug_link_ctrl_status_regs #(
	parameter integer BASE_DIV       = 3,
	parameter integer TICKS_PER_BIT  = 1,
	parameter integer TIMEOUT_CYCLES = `TIMEOUT_LINK_CYCLES,
	parameter integer DATA_W         = 8
) (
	input  wire              ref_clk,
	input  wire              resetn,
	input  wire              regAccess,
	input  wire              regWrite,
	input  wire [3:0]        regAddr,
	input  wire [7:0]        regWrData,
	output reg  [7:0]        regRdData,
	output reg               regRdValid,
	input  wire              parityFault,
	input  wire              stopFault,
	input  wire              startFault,
	input  wire              busFault,
	input  wire              contentionSeen,
	input  wire              accWaiting,
	input  wire              accResponse,
	output reg               accTimeout,
	input  wire              userRowKeyHit,
	input  wire              nvmKeyHit,
	input  wire              eraseKeyHit,
	input  wire              nvmProgStarted,
	input  wire              loadStoreBusy,
	input  wire              multiByteLoad,
	input  wire              rxToTx,
	input  wire [DATA_W-1:0] txData,
	input  wire              txValid,
	output wire              txReady,
	output wire [DATA_W-1:0] outData,
	output wire              outValid,
	input  wire              outReady,
	output wire              linkTick,
	output wire              parityCheckOn,
	output wire              collisionCheckOn,
	output wire              replySignatureOn,
	output reg               nackRequest,
	output wire              interfaceDown,
	output wire              sysclkRequest,
	output wire              sysResetOut,
	output reg               userRowCommit,
	output reg               userRowSessionEnd
);

	// ==================================================
	// register decode
	function isWrite;
		input [3:0] ofs;
		begin
			isWrite = regAccess && regWrite && (regAddr == ofs);
		end
	endfunction

	reg  [7:0] controlA;
	reg  [2:0] controlB;
	reg  [2:0] keys;
	reg  [7:0] systemResetWord;
	reg  [1:0] linkClockDiv;
	reg        sysclkHold;
	reg  [2:0] linkErrorCode;
	wire       offNow = controlB[`BIT_INTERFACE_OFF - 2];

	// ==================================================
	// configuration registers
	// resetn and interface off both load their reset values, but interface off keeps its own bit set until a write clears it
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			controlA        <= `RST_CONTROL_A;
			controlB        <= 3'h0;
			linkClockDiv    <= `RST_CLOCK_DIV;
			sysclkHold      <= 1'b1;
			systemResetWord <= `RESET_RUN;
		end else if (offNow) begin
			controlA        <= `RST_CONTROL_A;
			controlB        <= {2'h0, !(isWrite(`OFS_LINK_CONTROL_B) &&
				!regWrData[`BIT_INTERFACE_OFF])};
			linkClockDiv    <= `RST_CLOCK_DIV;
			sysclkHold      <= 1'b1;
			systemResetWord <= `RESET_RUN;
		end else begin
			if (isWrite(`OFS_LINK_CONTROL_A))
				controlA <= regWrData & 8'hbf;
			if (isWrite(`OFS_LINK_CONTROL_B))
				controlB <= regWrData[`BIT_NACK_OFF:`BIT_INTERFACE_OFF];
			if (isWrite(`OFS_LINK_CLOCK_CTL))
				linkClockDiv <= regWrData[1:0];
			if (isWrite(`OFS_SYSTEM_CONTROL))
				sysclkHold <= regWrData[`BIT_SYSCLK_HOLD];
			if (isWrite(`OFS_SYS_RESET_REQ))
				systemResetWord <= regWrData;
		end
	end

	assign sysResetOut      = (systemResetWord == `RESET_SIGNATURE);
	assign interfaceDown    = offNow;
	assign sysclkRequest    = sysclkHold && !offNow;
	assign parityCheckOn    = !offNow && !controlA[`BIT_PARITY_OFF];
	assign collisionCheckOn = !offNow && !controlB[`BIT_COLLISION_OFF - 2];
	assign replySignatureOn = !offNow && !controlA[`BIT_REPLY_SIG_OFF];

	// ==================================================
	// key status and system control strobes
	wire eraseClear = isWrite(`OFS_SYS_RESET_REQ) && (regWrData == `RESET_SIGNATURE);
	wire rowEnd     = isWrite(`OFS_KEY_STATUS) && regWrData[`BIT_USER_ROW_KEY];
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			keys              <= 3'h0;
			userRowCommit     <= 1'b0;
			userRowSessionEnd <= 1'b0;
		end else if (offNow) begin
			keys              <= 3'h0;
			userRowCommit     <= 1'b0;
			userRowSessionEnd <= 1'b0;
		end else begin
			keys[2] <= userRowKeyHit || (keys[2] && !rowEnd);
			userRowSessionEnd <= rowEnd;
			keys[1] <= nvmKeyHit || (keys[1] && !nvmProgStarted);
			keys[0] <= eraseKeyHit || (keys[0] && !eraseClear);
			userRowCommit <= isWrite(`OFS_SYSTEM_CONTROL) &&
				regWrData[`BIT_USER_ROW_DONE] && keys[2];
		end
	end

	// ==================================================
	// link clock enable
	reg  [7:0] divCount;
	wire [7:0] divLimit = (BASE_DIV[7:0] << linkClockDiv) - 8'h01;
	assign linkTick = !offNow && (divCount >= divLimit);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			divCount <= 8'h00;
		else if (offNow || linkTick)
			divCount <= 8'h00;
		else
			divCount <= divCount + 8'h01;
	end

	// ==================================================
	// access layer time-out
	reg [16:0] waitCount;
	wire timeoutHit = accWaiting && !accResponse && linkTick &&
		(waitCount == TIMEOUT_CYCLES[16:0] - 17'h1);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			waitCount  <= 17'h0;
			accTimeout <= 1'b0;
		end else begin
			accTimeout <= timeoutHit && !controlA[`BIT_TIMEOUT_OFF];
			if (!accWaiting || accResponse || offNow || timeoutHit)
				waitCount <= 17'h0;
			else if (linkTick)
				waitCount <= waitCount + 17'h1;
		end
	end

	// ==================================================
	// error code capture
	reg [2:0] next_code;
	always @* begin
		next_code = `ERR_NONE;
		if (contentionSeen && collisionCheckOn)
			next_code = `ERR_CONTENTION;
		else if (busFault)
			next_code = `ERR_BUS;
		else if (accTimeout)
			next_code = `ERR_TIMEOUT;
		else if (startFault)
			next_code = `ERR_CLOCK_RECOVERY;
		else if (stopFault)
			next_code = `ERR_FRAME;
		else if (parityFault && parityCheckOn)
			next_code = `ERR_PARITY;
	end
	wire codeRead = regAccess && !regWrite && (regAddr == `OFS_ERROR_STATUS);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			linkErrorCode <= `ERR_NONE;
		else if (offNow)
			linkErrorCode <= `ERR_NONE;
		else if (next_code != `ERR_NONE)
			linkErrorCode <= next_code;
		else if (codeRead)
			linkErrorCode <= `ERR_NONE;
	end

	// ==================================================
	// read port
	reg [7:0] next_rd;
	always @* begin
		next_rd = 8'h00;
		case (regAddr)
			`OFS_ERROR_STATUS:   next_rd = {5'h00, linkErrorCode};
			`OFS_LINK_CONTROL_A: next_rd = controlA;
			`OFS_LINK_CONTROL_B: next_rd = {3'h0, controlB, 2'h0};
			`OFS_KEY_STATUS:     next_rd = {2'h0, keys, 3'h0};
			`OFS_SYS_RESET_REQ:  next_rd = systemResetWord;
			`OFS_LINK_CLOCK_CTL: next_rd = {6'h00, linkClockDiv};
			`OFS_SYSTEM_CONTROL: next_rd = {7'h00, sysclkHold};
			default:             next_rd = 8'h00;
		endcase
	end
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData  <= 8'h00;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regAccess && !regWrite;
			if (regAccess && !regWrite)
				regRdData <= next_rd;
		end
	end

	// ==================================================
	// nack after system reset during a transfer
	reg resetSeen;
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			resetSeen   <= 1'b0;
			nackRequest <= 1'b0;
		end else begin
			resetSeen   <= sysResetOut;
			nackRequest <= sysResetOut && !resetSeen && loadStoreBusy &&
				!controlB[`BIT_NACK_OFF - 2] && !offNow;
		end
	end

	// ==================================================
	// two-entry transmit buffer
	reg [DATA_W-1:0] slot [0:1];
	reg              wrPtr;
	reg              rdPtr;
	reg  [1:0]       fill;
	wire             pushOk = txValid && txReady;
	wire             popOk  = outValid && outReady;
	// back-pressure reaches the source when both slots are taken
	assign txReady = !offNow && (fill != 2'h2);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			fill  <= 2'h0;
		end else if (offNow) begin
			wrPtr <= 1'b0;
			rdPtr <= 1'b0;
			fill  <= 2'h0;
		end else begin
			if (pushOk)
				wrPtr <= !wrPtr;
			if (popOk)
				rdPtr <= !rdPtr;
			fill <= fill + {1'b0, pushOk} - {1'b0, popOk};
		end
	end
	always @(posedge ref_clk) begin
		if (pushOk)
			slot[wrPtr] <= txData;
	end
	assign outData = slot[rdPtr];

	// ==================================================
	// guard time and inter-byte gap, counted in link ticks
	reg  [7:0]  guardCount;
	reg  [15:0] gapCount;
	localparam integer GAP_TICKS = `GAP_IDLE_BITS * TICKS_PER_BIT;
	wire [2:0]  guardSel = controlA[`GUARD_SEL_MSB:0];
	// reserved code falls back to the longest guard
	wire [7:0]  guardLoad = (guardSel == `GUARD_RESERVED) ? `GUARD_MAX_CYCLES :
		(`GUARD_MAX_CYCLES >> guardSel);
	assign outValid = (fill != 2'h0) && (guardCount == 8'h00) && (gapCount == 16'h0);
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			guardCount <= 8'h00;
			gapCount   <= 16'h0;
		end else if (offNow) begin
			guardCount <= 8'h00;
			gapCount   <= 16'h0;
		end else begin
			if (rxToTx)
				guardCount <= guardLoad;
			else if (linkTick && guardCount != 8'h00)
				guardCount <= guardCount - 8'h01;
			if (popOk && multiByteLoad && controlA[`BIT_INTER_BYTE_GAP])
				gapCount <= GAP_TICKS[15:0];
			else if (linkTick && gapCount != 16'h0)
				gapCount <= gapCount - 16'h1;
		end
	end
endmodule // debug_link_ctrl_status_regs
`default_nettype wire

/* File: debug_link_defs.vh */
// constants for the debug link control and status registers
`ifndef DEBUG_LINK_DEFS_VH
`define DEBUG_LINK_DEFS_VH
// ==================================================
// register offsets
`define OFS_ERROR_STATUS   4'h1
`define OFS_LINK_CONTROL_A 4'h2
`define OFS_LINK_CONTROL_B 4'h3
`define OFS_KEY_STATUS     4'h7
`define OFS_SYS_RESET_REQ  4'h8
`define OFS_LINK_CLOCK_CTL 4'h9
`define OFS_SYSTEM_CONTROL 4'ha
// ==================================================
// field positions
`define BIT_INTER_BYTE_GAP 7
`define BIT_PARITY_OFF     5
`define BIT_TIMEOUT_OFF    4
`define BIT_REPLY_SIG_OFF  3
`define GUARD_SEL_MSB      2
`define BIT_NACK_OFF       4
`define BIT_COLLISION_OFF  3
`define BIT_INTERFACE_OFF  2
`define BIT_USER_ROW_KEY   5
`define BIT_NVM_KEY        4
`define BIT_ERASE_KEY      3
`define BIT_USER_ROW_DONE  1
`define BIT_SYSCLK_HOLD    0
// ==================================================
// reset values and codes
`define RST_CONTROL_A      8'h00
`define RST_CONTROL_B      8'h00
`define RST_CLOCK_DIV      2'h3
`define RESET_SIGNATURE    8'h59
`define RESET_RUN          8'h00
`define ERR_NONE           3'h0
`define ERR_PARITY         3'h1
`define ERR_FRAME          3'h2
`define ERR_TIMEOUT        3'h3
`define ERR_CLOCK_RECOVERY 3'h4
`define ERR_BUS            3'h6
`define ERR_CONTENTION     3'h7
`define GUARD_RESERVED     3'h7
`define GUARD_MAX_CYCLES   8'h80
// ==================================================
// timing
`define TIMEOUT_LINK_CYCLES 65536
`define GAP_IDLE_BITS       2
`endif

/* File: debug_link_monitor.sv */
// port assertions for the debug link register block
`timescale 1ns/1ps
`default_nettype none
module debug_link_monitor (
	input wire logic       ref_clk,
	input wire logic       resetn,
	input wire logic       regAccess,
	input wire logic       regWrite,
	input wire logic [3:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	input wire logic       parityFault,
	input wire logic       stopFault,
	input wire logic       startFault,
	input wire logic       busFault,
	input wire logic       contentionSeen,
	input wire logic       accTimeout,
	input wire logic       parityCheckOn,
	input wire logic       collisionCheckOn,
	input wire logic       interfaceDown,
	input wire logic       sysclkRequest,
	input wire logic       txReady,
	input wire logic       sysResetOut,
	input wire logic       nackRequest,
	input wire logic       userRowCommit,
	input wire logic       userRowSessionEnd
);
	// ====
	// helpers
	wire wrReq = regAccess && regWrite;
	wire quiet = !(parityFault || stopFault || startFault || busFault
		|| contentionSeen || accTimeout);
	wire keyWr = wrReq && regAddr == 4'h7 && regWrData[5];
	wire doneWr = wrReq && regAddr == 4'ha && regWrData[1];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	// a new error in the same cycle wins, so reads must be quiet
	sequence s_err_read;
		regAccess && !regWrite && regAddr == 4'h1 && quiet;
	endsequence
	// ====
	// assertions
	AST_ERR_CLEAR: assert property (
		s_err_read ##1 quiet ##1 s_err_read |=> regRdData == 8'h00)
		else $error("error code survived a read");
	AST_RESET_WORD: assert property (
		wrReq && regAddr == 4'h8 && !interfaceDown |=> sysResetOut == ($past(regWrData) == 8'h59))
		else $error("system reset not tied to the reset word");
	AST_PARITY_OFF: assert property (
		wrReq && regAddr == 4'h2 && !interfaceDown |=> parityCheckOn != $past(regWrData[5]))
		else $error("parity check does not follow its bit");
	AST_COLLISION_OFF: assert property (
		wrReq && regAddr == 4'h3 && !regWrData[2] |=> collisionCheckOn != $past(regWrData[3]))
		else $error("collision check does not follow its bit");
	AST_OFF_DROPS: assert property (interfaceDown |-> !sysclkRequest && !txReady)
		else $error("interface off still requests clock or takes data");
	AST_NACK_AFTER_RESET: assert property (
		nackRequest |-> $past(sysResetOut) && !$past(sysResetOut, 2))
		else $error("negative acknowledge without a fresh system reset");
	AST_SESSION_END: assert property (userRowSessionEnd |-> $past(keyWr))
		else $error("session end without a key status write");
	AST_ROW_COMMIT: assert property (userRowCommit |-> $past(doneWr))
		else $error("user row commit without a done write");
endmodule // debug_link_monitor
bind debug_link_ctrl_status_regs debug_link_monitor i_debug_link_monitor (.ref_clk, .resetn,
	.regAccess, .regWrite, .regAddr, .regWrData, .regRdData, .parityFault, .stopFault,
	.startFault, .busFault, .contentionSeen, .accTimeout, .parityCheckOn, .collisionCheckOn,
	.interfaceDown, .sysclkRequest, .txReady, .sysResetOut, .nackRequest, .userRowCommit,
	.userRowSessionEnd);
`default_nettype wire

/* File: link_sink_model.sv */
// debugger side sink for bytes leaving the link buffer
`timescale 1ns/1ps
`default_nettype none
module link_sink_model (
	input  wire logic        ref_clk,
	input  wire logic        stall,
	input  wire logic [7:0]  outData,
	input  wire logic        outValid,
	output var  logic        outReady,
	output var  logic [15:0] lastTwo,
	output var  logic [7:0]  gotCount
);
	// ====
	// stalls only when told to, so no byte is dropped
	assign outReady = !stall;
	initial gotCount = 8'h00;
	always @(posedge ref_clk) begin
		if (outValid && outReady) begin
			lastTwo <= {lastTwo[7:0], outData};
			gotCount <= gotCount + 8'h01;
		end
	end
endmodule // link_sink_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the debug link register block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        ref_clk = 1'h0, resetn = 1'h0, regAccess = 1'h0, regWrite = 1'h0;
	logic [3:0]  regAddr = 4'h0;
	logic [7:0]  regWrData = 8'h00, ev = 8'h00, txData = 8'h00, n, gotCount;
	logic        accWaiting = 1'h0, nvmProgStarted = 1'h0, loadStoreBusy = 1'h0;
	logic        accResponse = 1'h0, multiByteLoad = 1'h0, rxToTx = 1'h0;
	logic        txValid = 1'h0, stall = 1'h1;
	logic [7:0]  toCnt = 8'h00, nackCnt = 8'h00, commitCnt = 8'h00, endCnt = 8'h00;
	logic [15:0] lastTwo;
	logic [7:0]  codes [5] = '{8'h01, 8'h02, 8'h04, 8'h06, 8'h07};
	wire  [7:0]  regRdData, outData;
	wire         regRdValid, accTimeout, txReady, outValid, outReady, linkTick;
	wire         parityCheckOn, collisionCheckOn, replySignatureOn, nackRequest, interfaceDown;
	wire         sysclkRequest, sysResetOut, userRowCommit, userRowSessionEnd;
	int          checks = 0, failures = 0, i;
	// ====
	// design and partner
	debug_link_ctrl_status_regs #(.TIMEOUT_CYCLES(8)) i_debug_link_ctrl_status_regs (.ref_clk,
		.resetn, .regAccess, .regWrite, .regAddr, .regWrData, .regRdData, .regRdValid,
		.parityFault(ev[0]), .stopFault(ev[1]), .startFault(ev[2]), .busFault(ev[3]),
		.contentionSeen(ev[4]), .accWaiting, .accResponse, .accTimeout,
		.userRowKeyHit(ev[7]), .nvmKeyHit(ev[6]), .eraseKeyHit(ev[5]), .nvmProgStarted,
		.loadStoreBusy, .multiByteLoad, .rxToTx, .txData, .txValid, .txReady,
		.outData, .outValid, .outReady, .linkTick, .parityCheckOn, .collisionCheckOn,
		.replySignatureOn, .nackRequest, .interfaceDown, .sysclkRequest, .sysResetOut,
		.userRowCommit, .userRowSessionEnd);
	link_sink_model i_link_sink_model (.ref_clk, .stall, .outData, .outValid, .outReady,
		.lastTwo, .gotCount);
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		toCnt <= toCnt + {7'h0, accTimeout};
		nackCnt <= nackCnt + {7'h0, nackRequest};
		commitCnt <= commitCnt + {7'h0, userRowCommit};
		endCnt <= endCnt + {7'h0, userRowSessionEnd};
	end
	// ====
	// tasks
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAccess <= 1'h1;
		regWrite <= w;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regAccess <= 1'h0;
		#1;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		acc(1'h1, a, d);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		acc(1'h0, a, 8'h00);
		chk("valid", 8'h01, {7'h0, regRdValid});
		chk("read", e, regRdData);
	endtask
	task pulse(input logic [7:0] m);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 8'h00;
	endtask
	task push(input logic [7:0] d);
		@(posedge ref_clk);
		txValid <= 1'h1;
		txData <= d;
		@(posedge ref_clk);
		txValid <= 1'h0;
		#1;
	endtask
	// edges from one link tick to the next
	task gap;
		n = 8'h00;
		do @(posedge ref_clk); while (!linkTick);
		do begin
			@(posedge ref_clk);
			n++;
		end while (!linkTick);
	endtask
	task stop_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ====
	// tests
	initial begin
		#100000;
		failures++;
		stop_test;
	end
	initial begin
		repeat (6) @(posedge ref_clk);
		resetn <= 1'h1;
		for (i = 1; i < 16; i++) rd(4'(i), (i == 9) ? 8'h03 : (i == 10) ? 8'h01 : 8'h00);
		rd(4'ha, 8'h01);
		for (i = 0; i < 4; i++) begin
			wr(4'h9, 8'(i));
			rd(4'h9, 8'(i));
			gap;
			chk("tick", 8'(3 << i), n);
		end
		for (i = 0; i < 5; i++) begin
			pulse(8'(1 << i));
			rd(4'h1, codes[i]);
			rd(4'h1, 8'h00);
		end
		pulse(8'h01);
		pulse(8'h08);
		rd(4'h1, 8'h06);
		wr(4'h2, 8'hff);
		rd(4'h2, 8'hbf);
		chk("parity", 8'h00, {7'h0, parityCheckOn});
		chk("reply", 8'h00, {7'h0, replySignatureOn});
		pulse(8'h01);
		rd(4'h1, 8'h00);
		wr(4'h2, 8'h00);
		wr(4'h9, 8'h00);
		accWaiting <= 1'h1;
		for (i = 0; i < 100 && toCnt == 8'h00; i++) @(posedge ref_clk);
		accWaiting <= 1'h0;
		chk("timeout", 8'h01, toCnt);
		rd(4'h1, 8'h03);
		rd(4'h1, 8'h00);
		// responses keep restarting the wait, so no time-out
		accWaiting <= 1'h1;
		repeat (5) begin
			repeat (12) @(posedge ref_clk);
			accResponse <= 1'h1;
			@(posedge ref_clk);
			accResponse <= 1'h0;
		end
		accWaiting <= 1'h0;
		chk("response", 8'h01, toCnt);
		wr(4'h2, 8'h10);
		accWaiting <= 1'h1;
		repeat (60) @(posedge ref_clk);
		accWaiting <= 1'h0;
		chk("timeout off", 8'h01, toCnt);
		wr(4'h2, 8'h81);
		pulse(8'h20);
		rd(4'h7, 8'h08);
		loadStoreBusy <= 1'h1;
		wr(4'h8, 8'h59);
		chk("sys reset", 8'h01, {7'h0, sysResetOut});
		rd(4'h7, 8'h00);
		rd(4'h2, 8'h81);
		wr(4'h8, 8'h5a);
		chk("sys release", 8'h00, {7'h0, sysResetOut});
		chk("nack", 8'h01, nackCnt);
		wr(4'h3, 8'h10);
		wr(4'h8, 8'h59);
		wr(4'h8, 8'h00);
		chk("nack off", 8'h01, nackCnt);
		loadStoreBusy <= 1'h0;
		wr(4'ha, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk("commit", 8'h00, commitCnt);
		pulse(8'h80);
		rd(4'h7, 8'h20);
		wr(4'ha, 8'h03);
		repeat (2) @(posedge ref_clk);
		chk("commit", 8'h01, commitCnt);
		wr(4'h7, 8'h20);
		rd(4'h7, 8'h00);
		chk("session", 8'h01, endCnt);
		pulse(8'h40);
		rd(4'h7, 8'h10);
		nvmProgStarted <= 1'h1;
		rd(4'h7, 8'h00);
		nvmProgStarted <= 1'h0;
		wr(4'h3, 8'h08);
		chk("collision", 8'h00, {7'h0, collisionCheckOn});
		push(8'ha5);
		push(8'h3c);
		chk("full", 8'h00, {7'h0, txReady});
		multiByteLoad <= 1'h1;
		stall <= 1'h0;
		// without the gap the second byte would leave one cycle later
		repeat (2) @(posedge ref_clk);
		#1;
		chk("gap", 8'h01, gotCount);
		repeat (20) @(posedge ref_clk);
		chk("drained", 8'h02, gotCount);
		chk("order", 8'ha5, lastTwo[15:8]);
		chk("last", 8'h3c, lastTwo[7:0]);
		// guard of four ticks, three cycles each at divider 0
		wr(4'h2, 8'h05);
		rxToTx <= 1'h1;
		@(posedge ref_clk);
		rxToTx <= 1'h0;
		push(8'h77);
		repeat (6) @(posedge ref_clk);
		#1;
		chk("guard", 8'h02, gotCount);
		repeat (12) @(posedge ref_clk);
		#1;
		chk("guard end", 8'h03, gotCount);
		chk("guard data", 8'h77, lastTwo[7:0]);
		multiByteLoad <= 1'h0;
		wr(4'h3, 8'h04);
		chk("clock req", 8'h00, {7'h0, sysclkRequest});
		wr(4'h3, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h9, 8'h03);
		rd(4'ha, 8'h01);
		stop_test;
	end
endmodule // tb
`default_nettype wire
